// ---- rtl/xts_aes_defs.svh ----
// constants of the xts round pipeline
`ifndef XTS_AES_DEFS_SVH
`define XTS_AES_DEFS_SVH
`define XA_KEY_STRIDE 32'h0000_0010
`define XA_LFSR_POLY 128'h0000_0000_0000_0000_0000_0000_0000_0087
`define XA_SBOX_AFFINE 8'h63
`define XA_GF_POLY 8'h1b
`define XA_ONE 8'h01
`define XA_ZERO128 128'h0000_0000_0000_0000_0000_0000_0000_0000
`define XA_ZERO32 32'h0000_0000
`define XA_BUF_FULL 2'h2
`define XA_BUF_EMPTY 2'h0
`define XA_BUF_ONE 2'h1
`define XA_RCON_LSB 0
`define XA_RCON_MSB 7
`endif

// ---- rtl/xts_aes_pkg.sv ----
// types shared by the xts round pipeline and its users
package xts_aes_pkg;
  typedef enum logic [2:0] {
    no_op = 3'b000,
    first_round_op = 3'b001,
    middle_round_op = 3'b010,
    last_round_op = 3'b011,
    key_expand_op = 3'b100,
    state_load_op = 3'b101,
    twiddle_load_op = 3'b110,
    twiddle_advance_op = 3'b111
  } op_t;

  typedef struct packed {
    op_t op;
    logic [31:0] addr;
  } issue_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic fast;
    logic [127:0] data;
    logic [31:0] addr;
  } stage_t;

  typedef struct packed {
    op_t op;
    logic [127:0] state;
    logic [31:0] addr;
    logic [127:0] twiddle;
  } result_t;
endpackage

// ---- rtl/xts_aes_round_pipeline.sv ----
// xts-aes round unit in the execute/memory/write-back pipe of a host core
// Overview of operation
// - the encrypted twiddle sits in a 128-bit register loaded from memory.
// - the twiddle steps to its next lfsr value in a single cycle.
// - key expansion yields the next round key in one cycle.
// - each op passes fetch, issue, execute, memory and write-back.
// - ops before write-back may be killed; a write-back op always commits.
// - operands are read in execute (in memory for fast rounds), addresses in execute, data in memory.
// - cipher logic sits in execute or later stages.
// - default rounds read state in execute and write it after memory.
// - an interlock stalls a dependent op so rounds issue every other cycle.
// - optional schedule runs the whole round in memory, one per cycle.
// - first xors twiddle and key, middle does all steps, last skips mix.
// - each round fetches its key at the address operand, then adds 16.
`timescale 1ns/100ps
`include "xts_aes_defs.svh"
module xts_aes_round_pipeline (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic op_valid_i,
  input wire xts_aes_pkg::issue_t op_i,
  input wire logic fast_schedule_i,
  input wire logic kill_i,
  output logic issue_ready_o,
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  input wire logic [127:0] memory_load_data_i,
  output logic result_valid_o,
  input wire logic result_ready_i,
  output xts_aes_pkg::result_t result_o,
  output logic [127:0] twiddle_o
);
  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = x[7] ? ({x[6:0], 1'b0} ^ `XA_GF_POLY) : {x[6:0], 1'b0};
    end
    return p;
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] t;
    logic [7:0] r;
    t = a;
    r = `XA_ONE;
    // a^254 is the field inverse, zero maps to zero
    for (int i = 0; i < 7; i++) begin
      t = gmul(t, t);
      r = gmul(r, t);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
      ^ {r[3:0], r[7:4]} ^ `XA_SBOX_AFFINE;
  endfunction

  function automatic logic [7:0] bsel(input logic [127:0] s, input int i);
    return s[127 - 8 * i -: 8];
  endfunction

  // pre-key part of a round; key is xored in memory stage
  function automatic logic [127:0] round_pre(input xts_aes_pkg::op_t op,
                                             input logic [127:0] s,
                                             input logic [127:0] t);
    logic [127:0] sh;
    logic [127:0] mx;
    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] a3;
    sh = `XA_ZERO128;
    mx = `XA_ZERO128;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        sh[127 - 8 * (r + 4 * c) -: 8] = sbox(bsel(s, r + 4 * ((c + r) % 4)));
      end
      a0 = bsel(sh, 4 * c);
      a1 = bsel(sh, 4 * c + 1);
      a2 = bsel(sh, 4 * c + 2);
      a3 = bsel(sh, 4 * c + 3);
      mx[127 - 32 * c -: 32] = {
        gmul(a0, 8'h02) ^ gmul(a1, 8'h03) ^ a2 ^ a3,
        a0 ^ gmul(a1, 8'h02) ^ gmul(a2, 8'h03) ^ a3,
        a0 ^ a1 ^ gmul(a2, 8'h02) ^ gmul(a3, 8'h03),
        gmul(a0, 8'h03) ^ a1 ^ a2 ^ gmul(a3, 8'h02)};
    end
    case (op)
      xts_aes_pkg::first_round_op: return s ^ t;
      xts_aes_pkg::last_round_op: return sh ^ t;
      default: return mx;
    endcase
  endfunction

  // next round key from previous key and round constant
  function automatic logic [127:0] key_step(input logic [127:0] k,
                                            input logic [7:0] rc);
    logic [31:0] g;
    logic [127:0] n;
    g = {sbox(k[23:16]) ^ rc, sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])};
    n[127:96] = k[127:96] ^ g;
    n[95:64] = k[95:64] ^ n[127:96];
    n[63:32] = k[63:32] ^ n[95:64];
    n[31:0] = k[31:0] ^ n[63:32];
    return n;
  endfunction

  function automatic logic writes_state(input xts_aes_pkg::op_t op);
    return op inside {xts_aes_pkg::first_round_op,
      xts_aes_pkg::middle_round_op, xts_aes_pkg::last_round_op,
      xts_aes_pkg::key_expand_op, xts_aes_pkg::state_load_op};
  endfunction

  function automatic logic is_round(input xts_aes_pkg::op_t op);
    return op inside {xts_aes_pkg::first_round_op,
      xts_aes_pkg::middle_round_op, xts_aes_pkg::last_round_op};
  endfunction

  // ----------------------------------------------------------------
  // pipeline state
  // ----------------------------------------------------------------
  xts_aes_pkg::stage_t e_q;
  xts_aes_pkg::stage_t m_q;
  xts_aes_pkg::stage_t w_q;
  xts_aes_pkg::stage_t next_e;
  xts_aes_pkg::stage_t next_m;
  xts_aes_pkg::stage_t next_w;
  logic [127:0] state;
  logic [127:0] twiddle_reg;
  logic [127:0] next_state;
  logic [127:0] next_twiddle;
  logic fast_meta;
  logic fast_sync;
  logic [127:0] fwd_state;
  logic [127:0] fwd_twiddle;
  logic [127:0] m_pre;
  logic hazard;
  logic advance;
  xts_aes_pkg::result_t push_data;

  always_comb begin
    // committed values forwarded from write-back
    fwd_state = (w_q.valid && writes_state(w_q.op)) ? w_q.data : state;
    fwd_twiddle = (w_q.valid && (w_q.op == xts_aes_pkg::twiddle_load_op
      || w_q.op == xts_aes_pkg::twiddle_advance_op)) ? w_q.data
      : twiddle_reg;
    // a reader other than a fast round waits at issue while its producer is still in execute
    hazard = op_valid_i && e_q.valid && e_q.op != xts_aes_pkg::no_op
      && op_i.op != xts_aes_pkg::state_load_op
      && op_i.op != xts_aes_pkg::twiddle_load_op
      && !(fast_sync && is_round(op_i.op));
    issue_ready_o = advance && !hazard;
    next_e = e_q;
    next_m = m_q;
    next_w = w_q;
    next_state = state;
    next_twiddle = twiddle_reg;
    m_pre = m_q.fast ? round_pre(m_q.op, fwd_state, fwd_twiddle)
      : m_q.data;
    if (advance) begin
      next_e.valid = op_valid_i && !hazard;
      next_e.op = op_i.op;
      next_e.addr = op_i.addr;
      next_e.fast = fast_sync && is_round(op_i.op);
      next_e.data = `XA_ZERO128;
      next_m = e_q;
      case (e_q.op)
        xts_aes_pkg::key_expand_op:
          next_m.data = key_step(fwd_state,
            e_q.addr[`XA_RCON_MSB:`XA_RCON_LSB]);
        xts_aes_pkg::twiddle_advance_op:
          next_m.data = {fwd_twiddle[126:0], 1'b0}
            ^ (fwd_twiddle[127] ? `XA_LFSR_POLY : `XA_ZERO128);
        default:
          next_m.data = round_pre(e_q.op, fwd_state, fwd_twiddle);
      endcase
      next_w = m_q;
      if (is_round(m_q.op)) begin
        next_w.data = m_pre ^ memory_load_data_i;
        next_w.addr = m_q.addr + `XA_KEY_STRIDE;
      end else if (m_q.op == xts_aes_pkg::state_load_op
                   || m_q.op == xts_aes_pkg::twiddle_load_op) begin
        next_w.data = memory_load_data_i;
      end
      if (w_q.valid && writes_state(w_q.op)) begin
        next_state = w_q.data;
      end
      if (w_q.valid && (w_q.op == xts_aes_pkg::twiddle_load_op
          || w_q.op == xts_aes_pkg::twiddle_advance_op)) begin
        next_twiddle = w_q.data;
      end
    end
    if (kill_i) begin
      next_e.valid = 1'b0;
      next_m.valid = 1'b0;
      if (advance) begin
        next_w.valid = 1'b0;
      end
    end
    if (advance && !m_q.valid) begin
      next_w.valid = 1'b0;
    end
    push_data.op = w_q.op;
    push_data.state = w_q.data;
    push_data.addr = w_q.addr;
    push_data.twiddle = fwd_twiddle;
  end

  always_ff @(posedge ref_clk_i) begin
    fast_meta <= fast_schedule_i;
    fast_sync <= fast_meta;
    if (sys_rst_i) begin
      e_q <= '0;
      m_q <= '0;
      w_q <= '0;
      state <= `XA_ZERO128;
      twiddle_reg <= `XA_ZERO128;
    end else begin
      e_q <= next_e;
      m_q <= next_m;
      w_q <= next_w;
      state <= next_state;
      twiddle_reg <= next_twiddle;
    end
  end

  assign mem_req_o = e_q.valid && (is_round(e_q.op)
    || e_q.op == xts_aes_pkg::state_load_op
    || e_q.op == xts_aes_pkg::twiddle_load_op);
  assign mem_addr_o = e_q.addr;
  assign twiddle_o = twiddle_reg;

  // ----------------------------------------------------------------
  // two-entry result buffer between write-back and the receiver
  // ----------------------------------------------------------------
  xts_aes_pkg::result_t buf_mem [2];
  xts_aes_pkg::result_t next_buf [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  logic next_rd_ptr;
  logic next_wr_ptr;
  logic [1:0] next_count;
  logic do_push;
  logic do_pop;

  always_comb begin
    advance = count != `XA_BUF_FULL;
    result_valid_o = count != `XA_BUF_EMPTY;
    result_o = buf_mem[rd_ptr];
    do_push = advance && w_q.valid;
    do_pop = result_valid_o && result_ready_i;
    next_buf = buf_mem;
    next_rd_ptr = rd_ptr ^ do_pop;
    next_wr_ptr = wr_ptr ^ do_push;
    next_count = count;
    if (do_push) begin
      next_buf[wr_ptr] = push_data;
    end
    if (do_push && !do_pop) begin
      next_count = count + `XA_BUF_ONE;
    end else if (!do_push && do_pop) begin
      next_count = count - `XA_BUF_ONE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= `XA_BUF_EMPTY;
    end else begin
      buf_mem <= next_buf;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the xts round pipeline
`timescale 1ns/100ps
`include "xts_aes_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
  logic ref_clk_i, sys_rst_i, op_valid_i, fast_schedule_i, kill_i;
  logic issue_ready_o, mem_req_o, result_valid_o, result_ready_i;
  logic [31:0] mem_addr_o, seed, a, k;
  logic [127:0] memory_load_data_i, twiddle_o, t;
  xts_aes_pkg::issue_t op_i;
  xts_aes_pkg::result_t result_o;
  xts_aes_pkg::result_t q[$];
  int fails, n_compared, cycles, taken;
  xts_aes_round_pipeline uut (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .op_valid_i(op_valid_i),
    .op_i(op_i),
    .fast_schedule_i(fast_schedule_i),
    .kill_i(kill_i),
    .issue_ready_o(issue_ready_o),
    .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o),
    .memory_load_data_i(memory_load_data_i),
    .result_valid_o(result_valid_o),
    .result_ready_i(result_ready_i),
    .result_o(result_o),
    .twiddle_o(twiddle_o));
  xts_mem_model mem (.ref_clk_i(ref_clk_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o),
    .frozen_i(!issue_ready_o && result_valid_o && !result_ready_i),
    .memory_load_data_o(memory_load_data_i));
  // --------
  // helpers
  // --------
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (!sys_rst_i && result_valid_o && result_ready_i) q.push_back(result_o);
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  function automatic logic [127:0] word(input logic [31:0] x);
    return {x, ~x, x, ~x};
  endfunction
  function automatic logic [127:0] step(input logic [127:0] v);
    return {v[126:0], 1'b0} ^ (v[127] ? `XA_LFSR_POLY : 128'h0);
  endfunction
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic issue(input xts_aes_pkg::op_t o, input logic [31:0] x);
    int n;
    n = 0;
    op_valid_i <= 1'b1;
    op_i <= '{o, x};
    @(posedge ref_clk_i);
    while (!issue_ready_o && n < 50) begin
      n++;
      @(posedge ref_clk_i);
    end
    if (!issue_ready_o) fails++;
  endtask
  task automatic idle(input int c);
    op_valid_i <= 1'b0;
    repeat (c) @(posedge ref_clk_i);
  endtask
  task give_verdict();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // --------
  // scenarios
  // --------
  initial begin
    ref_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_i = '0;
    fast_schedule_i = 1'b0;
    kill_i = 1'b0;
    result_ready_i = 1'b1;
    seed = 32'h0000_baf3;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    `CHK(twiddle_o, 128'h0)
    a = rnd() | 32'h8000_0000;
    issue(xts_aes_pkg::twiddle_load_op, a);
    t = word(a);
    for (int i = 0; i < 4; i++) begin
      issue(xts_aes_pkg::twiddle_advance_op, 32'h0);
      t = step(t);
    end
    idle(6);
    `CHK(q[0].twiddle, word(a))
    `CHK(twiddle_o, t)
    for (int i = 0; i < 4; i++) begin
      fast_schedule_i <= i[0];
      idle(4);
      q.delete();
      a = rnd();
      k = rnd();
      issue(xts_aes_pkg::state_load_op, a);
      issue(xts_aes_pkg::first_round_op, k);
      issue(xts_aes_pkg::middle_round_op, k + 32'h0000_0010);
      issue(xts_aes_pkg::last_round_op, k + 32'h0000_0020);
      issue(xts_aes_pkg::key_expand_op, a);
      idle(8);
      `CHK(q.size(), 5)
      `CHK(q[1].state, word(a) ^ t ^ word(k))
      `CHK(q[3].addr, k + 32'h0000_0030)
      `CHK(q[4].op, xts_aes_pkg::key_expand_op)
    end
    fast_schedule_i <= 1'b0;
    for (int d = 0; d < 3; d++) begin
      idle(6);
      q.delete();
      issue(xts_aes_pkg::state_load_op, rnd());
      op_valid_i <= 1'b0;
      repeat (d) @(posedge ref_clk_i);
      kill_i <= 1'b1;
      @(posedge ref_clk_i);
      kill_i <= 1'b0;
      idle(6);
      `CHK(q.size(), d / 2)
    end
    q.delete();
    result_ready_i <= 1'b0;
    op_valid_i <= 1'b1;
    op_i <= '{xts_aes_pkg::state_load_op, a};
    taken = 0;
    repeat (12) begin
      @(posedge ref_clk_i);
      if (issue_ready_o) taken++;
    end
    `CHK(issue_ready_o, 1'b0)
    result_ready_i <= 1'b1;
    idle(10);
    `CHK(q.size(), taken)
    `CHK(q[taken - 1].state, word(a))
    // mid-run reset, then one pass in program order with the twiddle clear
    sys_rst_i <= 1'b1;
    idle(3);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    `CHK(twiddle_o, 128'h0)
    `CHK(result_valid_o, 1'b0)
    q.delete();
    a = rnd();
    k = rnd();
    issue(xts_aes_pkg::state_load_op, a);
    issue(xts_aes_pkg::first_round_op, k);
    issue(xts_aes_pkg::twiddle_load_op, k + 32'h0000_0010);
    issue(xts_aes_pkg::key_expand_op, a);
    issue(xts_aes_pkg::no_op, a);
    idle(8);
    `CHK(q.size(), 5)
    `CHK(q[1].state, word(a) ^ word(k))
    `CHK(q[1].twiddle, 128'h0)
    `CHK(twiddle_o, word(k + 32'h0000_0010))
    `CHK(q[4].op, xts_aes_pkg::no_op)
    give_verdict();
  end
endmodule

// ---- testbench/xts_aes_round_pipeline_checker.sv ----
// port assertions for the xts round pipeline
`timescale 1ns/100ps
module xts_aes_round_pipeline_checker (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic op_valid_i,
  input wire xts_aes_pkg::issue_t op_i,
  input wire logic fast_schedule_i,
  input wire logic kill_i,
  input wire logic issue_ready_o,
  input wire logic mem_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic result_valid_o,
  input wire logic result_ready_i,
  input wire xts_aes_pkg::result_t result_o,
  input wire logic [127:0] twiddle_o
);
  // --------
  // helpers
  // --------
  logic take;
  logic rnd;
  assign take = op_valid_i && issue_ready_o && !kill_i;
  assign rnd = op_i.op inside {xts_aes_pkg::first_round_op,
    xts_aes_pkg::middle_round_op, xts_aes_pkg::last_round_op};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_clear: assert property ($fell(sys_rst_i) |->
    twiddle_o == 128'h0 && !result_valid_o && !mem_req_o)
    else $error("outputs not clear after reset");
  a_key_fetch: assert property (take && rnd ##1 !kill_i |->
    mem_req_o && mem_addr_o == $past(op_i.addr))
    else $error("key fetch address wrong");
  a_result_time: assert property (
    take ##1 (!kill_i && result_ready_i)[*3] |->
    ##1 result_valid_o && result_o.op == $past(op_i.op, 4))
    else $error("result late or wrong op");
  a_round_addr: assert property (
    take && rnd ##1 (!kill_i && result_ready_i)[*3] |->
    ##1 result_o.addr == $past(op_i.addr, 4) + 32'h0000_0010)
    else $error("address not stepped by 16");
  a_round_interlock: assert property (
    (!fast_schedule_i)[*3] ##0 take && op_i.op != xts_aes_pkg::no_op
    ##1 op_valid_i && rnd && !kill_i && !fast_schedule_i |-> !issue_ready_o)
    else $error("dependent round taken");
  a_fast_rate: assert property (
    (fast_schedule_i && result_ready_i)[*4] ##0 take && rnd
    ##1 op_valid_i && rnd && !kill_i |-> issue_ready_o)
    else $error("fast rounds not back to back");
  a_kill_exec: assert property (
    (!op_valid_i && result_ready_i)[*4] ##1 take ##1 kill_i
    ##1 (!op_valid_i && result_ready_i)[*3] |-> !result_valid_o)
    else $error("killed op produced a result");
  a_commit_w: assert property (
    take ##1 (!kill_i && result_ready_i)[*2] ##1 (kill_i && result_ready_i)
    |-> ##1 result_valid_o) else $error("write-back op dropped");
endmodule
bind xts_aes_round_pipeline xts_aes_round_pipeline_checker chk (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .op_valid_i(op_valid_i),
  .op_i(op_i),
  .fast_schedule_i(fast_schedule_i),
  .kill_i(kill_i),
  .issue_ready_o(issue_ready_o),
  .mem_req_o(mem_req_o),
  .mem_addr_o(mem_addr_o),
  .result_valid_o(result_valid_o),
  .result_ready_i(result_ready_i),
  .result_o(result_o),
  .twiddle_o(twiddle_o));

// ---- testbench/xts_mem_model.sv ----
// local data memory answering the pipeline's 128-bit loads
`timescale 1ns/100ps
module xts_mem_model (
  input wire logic ref_clk_i,
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic frozen_i,
  output logic [127:0] memory_load_data_o
);
  // --------
  // load path
  // --------
  initial memory_load_data_o = 128'h0;
  // word valid in memory stage, garbage otherwise
  always @(posedge ref_clk_i) begin
    if (!frozen_i) begin
      memory_load_data_o <= mem_req_i ? {mem_addr_i, ~mem_addr_i,
        mem_addr_i, ~mem_addr_i} : ~memory_load_data_o;
    end
  end
endmodule
